//--- pbio_pkg.sv
// Package: register map, field layouts and reset values of the I/O port
package pbio_pkg;
  localparam int PBIO_WIDTH = 8;
  localparam int PBIO_ANA_BITS = 6;
  // Register byte offsets
  localparam logic [7:0] PBIO_OFS_ANALOG = 8'h00;
  localparam logic [7:0] PBIO_OFS_DATA = 8'h04;
  localparam logic [7:0] PBIO_OFS_DIR = 8'h08;
  localparam logic [7:0] PBIO_OFS_PULLUP = 8'h0c;
  localparam logic [7:0] PBIO_OFS_CHGEN = 8'h10;
  localparam logic [7:0] PBIO_OFS_CONTROL = 8'h14;
  localparam logic [7:0] PBIO_OFS_STATUS = 8'h18;
  localparam logic [7:0] PBIO_OFS_MASK = 8'h1c;
  // Field positions
  localparam int PBIO_CTL_PUDIS_POS = 0;
  localparam int PBIO_STS_CHG_POS = 0;
  // Reset values
  localparam logic [5:0] PBIO_RST_ANALOG = 6'h3f;
  localparam logic [7:0] PBIO_RST_DIR = 8'hff;
  localparam logic [7:0] PBIO_RST_PULLUP = 8'hff;
  localparam logic [7:0] PBIO_RST_CHGEN = 8'h00;
  localparam logic [7:0] PBIO_RST_LATCH = 8'h00;
  localparam logic PBIO_RST_PUDIS = 1'b1;
  localparam logic PBIO_RST_MASK = 1'b0;
  // AXI responses
  localparam logic [1:0] PBIO_RESP_OKAY = 2'h0;
  localparam logic [1:0] PBIO_RESP_SLVERR = 2'h2;

  // Pin-side signals grouped per direction
  typedef struct packed {
    logic [7:0] pinOut;
    logic [7:0] pinOe;
    logic [7:0] pullupOn;
    logic [7:0] analogOn;
  } pbio_pad_t;
endpackage : pbio_pkg

//--- pbio_sync.sv
// Two-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
`default_nettype none
module pbio_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic rstSync_b,
  input wire logic clkEn,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] sync
);
  logic [WIDTH-1:0] stage1;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      stage1 <= '0;
      sync <= '0;
    end else if (clkEn) begin
      stage1 <= async;
      sync <= stage1;
    end
  end
endmodule : pbio_sync
`default_nettype wire

//--- pbio_change_det.sv
// Interrupt-on-change detector with last-read latch and sticky flag
`timescale 1ns/1ps
`default_nettype none
module pbio_change_det #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic rstSync_b,
  input wire logic clkEn,
  input wire logic [WIDTH-1:0] pinNow,
  input wire logic [WIDTH-1:0] enable,
  input wire logic portAccess,
  input wire logic flagClear,
  output logic mismatch,
  output logic flag
);
  logic [WIDTH-1:0] lastRead;
  logic [WIDTH-1:0] diff;

  // Per-pin mismatches ORed together
  assign diff = (pinNow ^ lastRead) & enable; // [RULE_11]
  assign mismatch = |diff;

  // Port access re-latches; flag set wins over clear
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      lastRead <= '0;
      flag <= 1'b0;
    end else if (clkEn) begin
      if (portAccess) begin
        lastRead <= pinNow; // [RULE_12]
      end
      if (mismatch && !portAccess) begin
        flag <= 1'b1; // [RULE_11]
      end else if (flagClear) begin
        flag <= 1'b0; // [RULE_12]
      end
    end
  end
endmodule : pbio_change_det
`default_nettype wire

//--- pbio_port.sv
// Eight-pin bidirectional port with pull-ups and change interrupt, AXI4-Lite
//
// The register offsets and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE_01: An analog-select bit of 1 makes its pin analog input, 0 digital.
// RULE_02: Analog-select bits 7-6 read zero and only bits 5-0 are stored.
// RULE_03: Analog pins lose digital input, pull-up and change interrupt.
// RULE_04: Software keeps analog pins configured as inputs.
// RULE_05: Pin-data reads return the sampled pin levels, 1 high, 0 low.
// RULE_06: Direction 1 tri-states the driver, 0 drives; reset all ones.
// RULE_07: Pull-up enable 1 turns on the pin's pull-up; reset all ones.
// RULE_08: Pull-ups act only while the global disable bit is cleared.
// RULE_09: A pin set as output has its pull-up forced off.
// RULE_10: Change enable 1 arms the pin's change interrupt; reset zero.
// RULE_11: Enabled pins differing from the last-read latch set the flag.
// RULE_12: Pin-data access re-latches; only then can the flag be cleared.
// RULE_13: A pin set as analog input always reads 0.
// RULE_14: Pin-data writes load the output latch driving output pins.
// RULE_15: Pin inputs are synchronised before reads and comparison.
module pbio_port (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clkEn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic [7:0] portPinsIn,
  output pbio_pkg::pbio_pad_t portPad,
  output logic irq
);
  localparam int W = pbio_pkg::PBIO_WIDTH;

  logic rstMeta_b;
  logic rstSync_b;
  logic [5:0] analogSelectBits;
  logic [W-1:0] outLatch;
  logic [W-1:0] pinDirection;
  logic [W-1:0] pullupEnable;
  logic [W-1:0] changeIntEnable;
  logic globalPullupDisable_n;
  logic intMask;
  logic [W-1:0] pinSync;
  logic [W-1:0] analogMask;
  logic [W-1:0] pinRead;
  logic portChangeFlag;
  logic changeMismatch;

  // Reset release through two flops
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_b <= 1'b0;
      rstSync_b <= 1'b0;
    end else begin
      rstMeta_b <= 1'b1;
      rstSync_b <= rstMeta_b;
    end
  end

  // Pin levels synchronised before any use
  pbio_sync #(.WIDTH(W)) uSync (
    .clk_sys(clk_sys),
    .rstSync_b(rstSync_b),
    .clkEn(clkEn),
    .async(portPinsIn),
    .sync(pinSync) // [RULE_15]
  );

  // Analog pins: bits 5-0 cover pins 5-0, upper pins stay digital
  assign analogMask = {2'b00, analogSelectBits}; // [RULE_01]
  // Analog pins read zero, digital ones their level
  assign pinRead = pinSync & ~analogMask; // [RULE_05] [RULE_13] [RULE_03]

  // ---- AXI write channel ----
  logic awHeld;
  logic wHeld;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic wrFire;
  logic wrLow;
  logic wrData;
  logic wrDir;
  logic wrPull;
  logic wrChg;
  logic wrCtl;
  logic wrSts;
  logic wrMsk;
  logic wrHit;
  logic rdFire;
  logic rdData;
  logic rdHit;
  logic [31:0] rdValue;

  // Readies stay low while the internal reset copy holds the flops
  assign s_axi_awready = clkEn && rstSync_b && !awHeld && !s_axi_bvalid;
  assign s_axi_wready = clkEn && rstSync_b && !wHeld && !s_axi_bvalid;
  assign wrFire = clkEn && awHeld && wHeld && !s_axi_bvalid;
  assign wrLow = wStrb[0];

  // Address decode of the write
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a[7:2] == ofs[7:2]);
  endfunction : hit

  assign wrData = wrFire && hit(awAddr, pbio_pkg::PBIO_OFS_DATA);
  assign wrDir = wrFire && hit(awAddr, pbio_pkg::PBIO_OFS_DIR);
  assign wrPull = wrFire && hit(awAddr, pbio_pkg::PBIO_OFS_PULLUP);
  assign wrChg = wrFire && hit(awAddr, pbio_pkg::PBIO_OFS_CHGEN);
  assign wrCtl = wrFire && hit(awAddr, pbio_pkg::PBIO_OFS_CONTROL);
  assign wrSts = wrFire && hit(awAddr, pbio_pkg::PBIO_OFS_STATUS);
  assign wrMsk = wrFire && hit(awAddr, pbio_pkg::PBIO_OFS_MASK);
  assign wrHit = wrData || wrDir || wrPull || wrChg || wrCtl || wrSts ||
                 wrMsk || (wrFire && hit(awAddr, pbio_pkg::PBIO_OFS_ANALOG));

  // Capture address and data in either order, answer once both held
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pbio_pkg::PBIO_RESP_OKAY;
    end else if (clkEn) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? pbio_pkg::PBIO_RESP_OKAY
                             : pbio_pkg::PBIO_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration registers, written through byte lane 0
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      analogSelectBits <= pbio_pkg::PBIO_RST_ANALOG;
      outLatch <= pbio_pkg::PBIO_RST_LATCH;
      pinDirection <= pbio_pkg::PBIO_RST_DIR; // [RULE_06]
      pullupEnable <= pbio_pkg::PBIO_RST_PULLUP; // [RULE_07]
      changeIntEnable <= pbio_pkg::PBIO_RST_CHGEN; // [RULE_10]
      globalPullupDisable_n <= pbio_pkg::PBIO_RST_PUDIS;
      intMask <= pbio_pkg::PBIO_RST_MASK;
    end else if (clkEn && wrLow) begin
      if (wrFire && hit(awAddr, pbio_pkg::PBIO_OFS_ANALOG)) begin
        analogSelectBits <= wData[5:0]; // [RULE_02]
      end
      if (wrData) begin
        outLatch <= wData[7:0]; // [RULE_14]
      end
      if (wrDir) begin
        pinDirection <= wData[7:0];
      end
      if (wrPull) begin
        pullupEnable <= wData[7:0];
      end
      if (wrChg) begin
        changeIntEnable <= wData[7:0];
      end
      if (wrCtl) begin
        globalPullupDisable_n <= wData[pbio_pkg::PBIO_CTL_PUDIS_POS];
      end
      if (wrMsk) begin
        intMask <= wData[pbio_pkg::PBIO_STS_CHG_POS];
      end
    end
  end

  // ---- AXI read channel ----
  assign s_axi_arready = clkEn && rstSync_b && !s_axi_rvalid;
  assign rdFire = s_axi_arvalid && s_axi_arready;
  assign rdData = rdFire && hit(s_axi_araddr, pbio_pkg::PBIO_OFS_DATA);

  // Read data selection
  always_comb begin
    rdHit = 1'b1;
    rdValue = 32'h0000_0000;
    unique case (s_axi_araddr[7:2])
      pbio_pkg::PBIO_OFS_ANALOG[7:2]: rdValue[5:0] = analogSelectBits;
      pbio_pkg::PBIO_OFS_DATA[7:2]: rdValue[7:0] = pinRead; // [RULE_05]
      pbio_pkg::PBIO_OFS_DIR[7:2]: rdValue[7:0] = pinDirection;
      pbio_pkg::PBIO_OFS_PULLUP[7:2]: rdValue[7:0] = pullupEnable;
      pbio_pkg::PBIO_OFS_CHGEN[7:2]: rdValue[7:0] = changeIntEnable;
      pbio_pkg::PBIO_OFS_CONTROL[7:2]:
        rdValue[pbio_pkg::PBIO_CTL_PUDIS_POS] = globalPullupDisable_n;
      pbio_pkg::PBIO_OFS_STATUS[7:2]:
        rdValue[pbio_pkg::PBIO_STS_CHG_POS] = portChangeFlag;
      pbio_pkg::PBIO_OFS_MASK[7:2]:
        rdValue[pbio_pkg::PBIO_STS_CHG_POS] = intMask;
      default: rdHit = 1'b0;
    endcase
  end

  // Read answer registered one cycle after the address is taken
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= pbio_pkg::PBIO_RESP_OKAY;
    end else if (clkEn) begin
      if (rdFire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdValue;
        s_axi_rresp <= rdHit ? pbio_pkg::PBIO_RESP_OKAY
                             : pbio_pkg::PBIO_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Change detector, analog pins excluded; any pin-data read or write re-latches
  pbio_change_det #(.WIDTH(W)) uChange (
    .clk_sys(clk_sys),
    .rstSync_b(rstSync_b),
    .clkEn(clkEn),
    .pinNow(pinSync), // [RULE_15]
    .enable(changeIntEnable & ~analogMask), // [RULE_03] [RULE_10]
    .portAccess(rdData || wrData), // [RULE_12]
    .flagClear(wrSts && wrLow && wData[pbio_pkg::PBIO_STS_CHG_POS]),
    .mismatch(changeMismatch),
    .flag(portChangeFlag)
  );

  // Level interrupt while the unmasked flag stands
  assign irq = portChangeFlag && intMask;

  // Pull-up only on digital input pins while the global disable is clear
  logic [W-1:0] pullupGate;
  assign pullupGate = pullupEnable & pinDirection & ~analogMask &
                      {W{~globalPullupDisable_n}};
                      // [RULE_07] [RULE_08] [RULE_09] [RULE_03]

  // Pad controls driven as one word: latch, driver per direction, pull-up
  assign portPad = '{pinOut: outLatch, // [RULE_14]
                     pinOe: ~pinDirection, // [RULE_06]
                     pullupOn: pullupGate,
                     analogOn: analogMask}; // [RULE_01]
endmodule : pbio_port
`default_nettype wire

//--- pbio_port_asserts.sv
// Checker of pad-side and reset relations of the I/O port
`timescale 1ns/1ps
`default_nettype none
module pbio_port_asserts (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic s_axi_bvalid,
  input wire pbio_pkg::pbio_pad_t portPad,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Pad controls agree with each other
  AST_PU_OUT:
    assert property ((portPad.pullupOn & portPad.pinOe) == 8'h00)
    else $error("pull-up on a driven pin");
  AST_PU_ANA:
    assert property ((portPad.pullupOn & portPad.analogOn) == 8'h00)
    else $error("pull-up on an analog pin");
  AST_ANA_TOP:
    assert property (portPad.analogOn[7:6] == 2'h0)
    else $error("analog select above bit 5");
  // State seen at the release of reset
  AST_RST_DRV:
    assert property ($rose(rst_b) |-> portPad.pinOe == 8'h00)
    else $error("driver on at reset");
  AST_RST_PU:
    assert property ($rose(rst_b) |-> portPad.pullupOn == 8'h00)
    else $error("pull-up on at reset");
  AST_IRQ_RST:
    assert property ($rose(rst_b) |-> !irq [*8])
    else $error("interrupt soon after reset");
  // Pad controls move only with a completed register write
  AST_LATCH_WR:
    assert property ($changed(portPad.pinOut) |-> $rose(s_axi_bvalid))
    else $error("output latch moved without a write");
  AST_DIR_WR:
    assert property ($changed(portPad.pinOe) |-> $rose(s_axi_bvalid))
    else $error("driver enable moved without a write");
endmodule : pbio_port_asserts
bind pbio_port pbio_port_asserts i_chk (.clk_sys(clk_sys), .rst_b(rst_b),
  .s_axi_bvalid(s_axi_bvalid), .portPad(portPad), .irq(irq));
`default_nettype wire

//--- pbio_pins_model.sv
// Behavioural model of the circuitry on the eight port pins
`timescale 1ns/1ps
`default_nettype none
module pbio_pins_model (
  input wire logic clk_sys,
  input wire pbio_pkg::pbio_pad_t portPad,
  input wire logic [7:0] extVal,
  input wire logic [7:0] extEn,
  output logic [7:0] portPinsIn
);
  logic [7:0] drift = 8'h55;
  // Floating pins wander so a stale level is never read back
  always @(posedge clk_sys) drift <= ~drift;
  // Port driver first, then outside source, then pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (portPad.pinOe[i]) portPinsIn[i] = portPad.pinOut[i];
      else if (extEn[i]) portPinsIn[i] = extVal[i];
      else if (portPad.pullupOn[i]) portPinsIn[i] = 1'b1;
      else portPinsIn[i] = drift[i];
    end
  end
endmodule : pbio_pins_model
`default_nettype wire

//--- pbio_port_tb.sv
// Self-checking bench of the I/O port over its register bus and pins
`timescale 1ns/1ps
`default_nettype none
module pbio_port_tb;
  localparam logic [7:0] aAna = pbio_pkg::PBIO_OFS_ANALOG;
  localparam logic [7:0] aDat = pbio_pkg::PBIO_OFS_DATA;
  localparam logic [7:0] aDir = pbio_pkg::PBIO_OFS_DIR;
  localparam logic [7:0] aPu = pbio_pkg::PBIO_OFS_PULLUP;
  localparam logic [7:0] aChg = pbio_pkg::PBIO_OFS_CHGEN;
  localparam logic [7:0] aCtl = pbio_pkg::PBIO_OFS_CONTROL;
  localparam logic [7:0] aSts = pbio_pkg::PBIO_OFS_STATUS;
  localparam logic [7:0] aMsk = pbio_pkg::PBIO_OFS_MASK;
  localparam logic [1:0] ok = pbio_pkg::PBIO_RESP_OKAY;
  localparam logic [1:0] err = pbio_pkg::PBIO_RESP_SLVERR;
  logic clk_sys = 1'b0, rst_b = 1'b0, clkEn = 1'b1, irq;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0;
  logic arValid = 1'b0, rReady = 1'b0, awReady, wReady, bValid;
  logic arReady, rValid;
  logic [7:0] awAddr = 8'h00, arAddr = 8'h00, extVal = 8'h00;
  logic [7:0] extEn = 8'h00, portPinsIn, v, r;
  logic [31:0] wData = 32'h0, rData;
  logic [3:0] wStrb = 4'hf;
  logic [1:0] bResp, rResp;
  logic [33:0] note;
  logic [1:0] qW[$];
  logic [33:0] qR[$];
  pbio_pkg::pbio_pad_t portPad;
  int failures = 0;
  int n_tests = 0;
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  pbio_port i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .clkEn(clkEn),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .portPinsIn(portPinsIn), .portPad(portPad),
    .irq(irq));
  pbio_pins_model i_pins (.clk_sys(clk_sys), .portPad(portPad),
    .extVal(extVal), .extEn(extEn), .portPinsIn(portPinsIn));
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  // Write one word; channels drop as each is taken
  task automatic wr(logic [7:0] a, logic [7:0] d, logic [1:0] e);
    logic aw, w, b;
    awAddr <= a;
    wData <= {24'h0, d};
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    qW.push_back(e);
    b = 1'b0;
    while (!b) begin
      @(negedge clk_sys);
      aw = awReady;
      w = wReady;
      b = bValid;
      @(posedge clk_sys);
      if (aw) awValid <= 1'b0;
      if (w) wValid <= 1'b0;
    end
    bReady <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  // Read one word; expectation goes to the note queue
  task automatic rd(logic [7:0] a, logic [31:0] d, logic [1:0] e);
    logic ar, b;
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    qR.push_back({e, d});
    b = 1'b0;
    while (!b) begin
      @(negedge clk_sys);
      ar = arReady;
      b = rValid;
      @(posedge clk_sys);
      if (ar) arValid <= 1'b0;
    end
    rReady <= 1'b0;
    @(posedge clk_sys);
  endtask : rd
  task automatic close_out;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  // Match each bus answer against the oldest note
  always @(negedge clk_sys) begin
    if (bValid === 1'b1 && bReady) chk("bresp", qW.pop_front(), bResp);
    if (rValid === 1'b1 && rReady) begin
      note = qR.pop_front();
      chk("rresp", {30'h0, note[33:32]}, {30'h0, rResp});
      chk("rdata", note[31:0], rData);
    end
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    close_out();
  end
  initial begin
    void'($urandom(41871));
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(aAna, 32'h3f, ok);
    rd(aDir, 32'hff, ok);
    rd(aPu, 32'hff, ok);
    rd(aChg, 32'h0, ok);
    rd(aCtl, 32'h1, ok);
    wr(aAna, 8'hff, ok);
    rd(aAna, 32'h3f, ok);
    // Latch loads while pins are inputs, then drives them
    r = 8'($urandom());
    wr(aAna, 8'h00, ok);
    wr(aDat, r, ok);
    chk("pinOut", {24'h0, r}, {24'h0, portPad.pinOut});
    chk("pinOe", 32'h0, {24'h0, portPad.pinOe});
    wr(aDir, 8'h00, ok);
    chk("pinOe", 32'hff, {24'h0, portPad.pinOe});
    rd(aDat, {24'h0, r}, ok);
    // Outside levels read back; analog pins read zero
    wr(aDir, 8'hff, ok);
    v = 8'($urandom());
    extVal <= v;
    extEn <= 8'hff;
    repeat (3) @(posedge clk_sys);
    rd(aDat, {24'h0, v}, ok);
    wr(aAna, 8'h0f, ok);
    chk("ana", 32'h0f, {24'h0, portPad.analogOn});
    rd(aDat, {24'h0, v & 8'hf0}, ok);
    // Pull-ups gated by global bit, direction and analog select
    extEn <= 8'h00;
    wr(aAna, 8'h03, ok);
    wr(aDir, 8'hf3, ok);
    wr(aCtl, 8'h00, ok);
    chk("pu", 32'hf0, {24'h0, portPad.pullupOn});
    wr(aPu, 8'h5f, ok);
    chk("pu", 32'h50, {24'h0, portPad.pullupOn});
    wr(aCtl, 8'h01, ok);
    chk("pu", 32'h0, {24'h0, portPad.pullupOn});
    // Change interrupt on enabled pin only, masked and cleared
    wr(aAna, 8'h00, ok);
    wr(aDir, 8'hff, ok);
    extEn <= 8'hff;
    wr(aMsk, 8'h01, ok);
    rd(aDat, {24'h0, v}, ok);
    wr(aChg, 8'h01, ok);
    extVal <= v ^ 8'h02;
    repeat (4) @(posedge clk_sys);
    chk("irq", 32'h0, {31'h0, irq});
    extVal <= v ^ 8'h03;
    repeat (4) @(posedge clk_sys);
    chk("irq", 32'h1, {31'h0, irq});
    wr(aMsk, 8'h00, ok);
    chk("irq", 32'h0, {31'h0, irq});
    wr(aMsk, 8'h01, ok);
    wr(aSts, 8'h01, ok);
    rd(aSts, 32'h1, ok);
    rd(aDat, {24'h0, v ^ 8'h03}, ok);
    wr(aSts, 8'h01, ok);
    rd(aSts, 32'h0, ok);
    chk("irq", 32'h0, {31'h0, irq});
    // Low clock enable freezes the change path; lane 0 off writes nothing
    clkEn <= 1'b0;
    extVal <= v ^ 8'h02;
    repeat (6) @(posedge clk_sys);
    chk("irq", 32'h0, {31'h0, irq});
    clkEn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("irq", 32'h1, {31'h0, irq});
    wStrb <= 4'he;
    wr(aMsk, 8'h00, ok);
    wStrb <= 4'hf;
    chk("irq", 32'h1, {31'h0, irq});
    // Unmapped address answers with an error and reads zero
    wr(8'h20, 8'hff, err);
    rd(8'h20, 32'h0, err);
    close_out();
  end
endmodule : pbio_port_tb
`default_nettype wire
